// ==== dv/ssf_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module ssf_monitor #(
  parameter int UNIT_MAP_W = 16
) (
  // Bus
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  // Flags
  input wire ssf_pkg::ssf_cond_s COND,
  input wire logic [UNIT_MAP_W-1:0] UNIT_MAP,
  input wire logic RESET_CMD,
  input wire logic [31:0] STATUS_WORD
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  wire logic rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
  a_upper_zero: assert property (STATUS_WORD[31:16] == 16'h0000)
    else $error("upper half set");
  a_field_map: assert property
    (!RESET_CMD |=> STATUS_WORD[14:3] == $past(COND[13:2]))
    else $error("field mismatch");
  a_startup_or: assert property
    (STATUS_WORD[2] == |STATUS_WORD[6:3]) else $error("bit 2 wrong");
  a_watchdog_bits: assert property
    (!RESET_CMD |=> STATUS_WORD[1:0] == $past(COND[1:0]))
    else $error("watchdog bits wrong");
  a_live_sticky: assert property
    (STATUS_WORD[15] && !RESET_CMD |=> STATUS_WORD[15])
    else $error("bit 15 dropped");
  a_cmd_clears: assert property
    (RESET_CMD |=> STATUS_WORD == 32'h0000_0000) else $error("not cleared");
  // Snapshot edges after a reset are excluded, they set the reference
  a_change_sets: assert property
    ($changed(UNIT_MAP) && !$past(RESET) && !$past(RESET_CMD) && !RESET_CMD
     ##1 !RESET_CMD |-> ##[0:1] STATUS_WORD[15]) else $error("change missed");
  a_read_word: assert property
    (rd && HADDR[11:0] == 12'h000 ##1 $stable(STATUS_WORD)
     |-> HRDATA == STATUS_WORD) else $error("read data wrong");
  c_read: cover property (rd ##1 HRDATA != 32'h0000_0000);
  c_live: cover property ($rose(STATUS_WORD[15]));
  c_cmd: cover property (STATUS_WORD[15] ##1 RESET_CMD);
endmodule : ssf_monitor
bind ssf_status ssf_monitor #(.UNIT_MAP_W(UNIT_MAP_W)) mon (.MCLK, .RESET,
  .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA, .COND, .UNIT_MAP,
  .RESET_CMD, .STATUS_WORD);
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic MCLK = 0, RESET = 1, HSEL = 0, HWRITE = 0, RESET_CMD = 0;
  logic HREADYOUT, HRESP;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, STATUS_WORD, r;
  logic [1:0] HTRANS = '0;
  logic [15:0] UNIT_MAP = '0;
  ssf_pkg::ssf_cond_s COND = '0;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #50 MCLK = ~MCLK;
  ssf_status uut (.MCLK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .COND, .UNIT_MAP, .RESET_CMD, .STATUS_WORD);
  task automatic chk(input logic [31:0] s, e, input string n);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Entered just after a rising edge; leaves just after one
  task automatic bus(input logic w, input logic [31:0] a, d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
    chk({31'h0000_0000, HRESP}, 32'h0000_0000, "hresp");
  endtask : bus
  task automatic put(input logic [13:0] c, input logic [31:0] e, string n);
    COND <= c;
    repeat (2) @(posedge MCLK);
    bus(1'b0, 32'h0000_0000, '0);
    chk(r, e, n);
    chk(STATUS_WORD, e, "status_word");
  endtask : put
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      conclude();
    end
  end
  initial
  begin
    logic [13:0] c;
    repeat (10) @(posedge MCLK);
    RESET <= 1'b0;
    put(14'h0000, '0, "reset");
    // Last pass sets every flag, code 7 included
    for (int i = 0; i < 15; i++)
    begin
      c = (i < 14) ? 14'h0001 << i : 14'h3fff;
      put(c, {17'h0_0000, c[13:2], |c[5:2], c[1:0]}, "cond");
    end
    $display("test cond done");
    bus(1'b1, 32'h0000_0000, 32'hffff_ffff);
    put(14'h0000, '0, "write");
    bus(1'b0, 32'h0000_0010, '0);
    chk(r, '0, "unmapped");
    $display("test bus done");
    UNIT_MAP <= 16'h0001;
    put(14'h0000, 32'h0000_8000, "live");
    UNIT_MAP <= 16'h0000;
    put(14'h0001, 32'h0000_8001, "sticky");
    RESET_CMD <= 1'b1;
    UNIT_MAP <= 16'h0003;
    @(posedge MCLK);
    RESET_CMD <= 1'b0;
    put(14'h0000, '0, "cleared");
    bus(1'b0, 32'h0000_0004, '0);
    chk(r, 32'h0000_0003, "snapshot");
    $display("test live done");
    conclude();
  end
endmodule : testbench
`default_nettype wire

// ==== verilog/ssf_defs.svh ====
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define SSF_ADDR_STATUS 32'h0000_0000
`define SSF_ADDR_SOURCE 32'h0000_0004
`define SSF_ADDR_WIDTH 12

// ****************************************
// Field positions
// ****************************************
`define SSF_BIT_WDT_BG 0
`define SSF_BIT_WDT_RT 1
`define SSF_BIT_STARTUP 2
`define SSF_BIT_PROJECT 3
`define SSF_BIT_SAVED 4
`define SSF_BIT_DIFFERS 5
`define SSF_BIT_FILESET 6
`define SSF_BIT_DEFAULT 7
`define SSF_BIT_CLOCKS 8
`define SSF_BIT_ABORT 9
`define SSF_BIT_BUFFER 10
`define SSF_BIT_PROGRAM 11
`define SSF_BIT_CODE_LO 12
`define SSF_BIT_CODE_HI 14
`define SSF_BIT_LIVE 15

// ****************************************
// Reset values
// ****************************************
`define SSF_RESET_STATUS 32'h0000_0000

// ****************************************
// AHB encodings
// ****************************************
`define SSF_HTRANS_NONSEQ 2'h2
`define SSF_HTRANS_SEQ 2'h3
`define SSF_HRESP_OKAY 1'h0

`endif

// ==== verilog/ssf_pkg.sv ====
package ssf_pkg;

  // Condition inputs from the controller's firmware and monitors
  typedef struct packed {
    logic [2:0] unit_config_error_code;
    logic program_exceeds_store;
    logic buffer_exceeds_ram;
    logic global_abort_stop;
    logic missing_phase_servo_clock;
    logic factory_default_state;
    logic system_file_setting_error;
    logic config_differs_from_save;
    logic saved_settings_error;
    logic project_file_read_error;
    logic rt_watchdog_expired;
    logic bg_watchdog_expired;
  } ssf_cond_s;

  // Pending AHB data phase
  typedef struct packed {
    logic active;
    logic write;
    logic [11:0] addr;
  } ssf_phase_s;

endpackage : ssf_pkg

// ==== verilog/ssf_status.sv ====
// Function
// - Status is one 32-bit word; bits 31 to 16 read zero.
// - Word lives only in flops; cleared by power-up reset.
// - Bit 15 sets when expansion units or end cover change live.
// - Bits 14 to 12 carry the three-bit unit configuration error code.
// - Bit 11 set when program exceeds nonvolatile store.
// - Bit 10 set when buffer allocation exceeds working RAM.
// - Bit 9 set while stopped by global abort-all.
// - Bit 8 set when phase or servo clock is missing.
// - Bit 6 flags system file setting error; bit 7 factory default.
// - Bit 5 set when hardware differs from last saved configuration.
// - Bit 4 set when saved settings fail on load.
// - Bit 3 set when user project file read fails.
// - Bit 2 is OR of bits 3 through 6.
// - Bit 1 set on real-time task watchdog expiry.
// - Bit 0 set on background task watchdog expiry.
// - Hardware-change flag reads 0 before a live change, 1 after.
// - Unit configuration is compared every cycle, not just at start.
// - Hardware-change flag sticks until reset; operation continues.
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "ssf_defs.svh"

module ssf_status #(
  parameter int UNIT_MAP_W = 16
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Conditions
  input wire ssf_pkg::ssf_cond_s COND,
  input wire logic [UNIT_MAP_W-1:0] UNIT_MAP,
  input wire logic RESET_CMD,
  // Status out
  output logic [31:0] STATUS_WORD
);

  // ****************************************
  // Hardware-change tracking
  // ****************************************
  logic [UNIT_MAP_W-1:0] unit_map_ref;
  logic map_valid;
  logic unit_config_changed_live;
  logic clear_all;

  // Power cycle or full reset command wipes the word
  assign clear_all = RESET | RESET_CMD;

  always_ff @(posedge MCLK)
  begin
    if (clear_all)
    begin
      map_valid <= 1'b0;
      unit_map_ref <= '0;
    end
    else
    begin
      // Snapshot first so start-up layout is not counted as a change
      map_valid <= 1'b1;
      if (!map_valid)
        unit_map_ref <= UNIT_MAP;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (clear_all)
      unit_config_changed_live <= 1'b0;
    else if (map_valid && UNIT_MAP != unit_map_ref)
      unit_config_changed_live <= 1'b1;
  end

  // ****************************************
  // Status word assembly
  // ****************************************
  logic [31:0] next_status;
  logic [31:0] status;

  always_comb
  begin
    next_status = `SSF_RESET_STATUS;
    next_status[`SSF_BIT_LIVE] = unit_config_changed_live;
    next_status[`SSF_BIT_CODE_HI:`SSF_BIT_CODE_LO] =
      COND.unit_config_error_code;
    next_status[`SSF_BIT_PROGRAM] = COND.program_exceeds_store;
    next_status[`SSF_BIT_BUFFER] = COND.buffer_exceeds_ram;
    next_status[`SSF_BIT_ABORT] = COND.global_abort_stop;
    next_status[`SSF_BIT_CLOCKS] =
      COND.missing_phase_servo_clock;
    next_status[`SSF_BIT_DEFAULT] = COND.factory_default_state;
    next_status[`SSF_BIT_FILESET] =
      COND.system_file_setting_error;
    next_status[`SSF_BIT_DIFFERS] =
      COND.config_differs_from_save;
    next_status[`SSF_BIT_SAVED] = COND.saved_settings_error;
    next_status[`SSF_BIT_PROJECT] =
      COND.project_file_read_error;
    next_status[`SSF_BIT_STARTUP] = COND.project_file_read_error |
      COND.saved_settings_error | COND.config_differs_from_save |
      COND.system_file_setting_error;
    next_status[`SSF_BIT_WDT_RT] = COND.rt_watchdog_expired;
    next_status[`SSF_BIT_WDT_BG] = COND.bg_watchdog_expired;
  end

  always_ff @(posedge MCLK)
  begin
    if (clear_all)
      status <= `SSF_RESET_STATUS;
    else
      status <= next_status;
  end

  assign STATUS_WORD = status;

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  ssf_pkg::ssf_phase_s phase;
  logic take;

  assign take = HSEL & HREADY & HTRANS[1];

  always_ff @(posedge MCLK)
  begin
    if (RESET)
      phase <= '0;
    else if (HREADY)
    begin
      phase.active <= take;
      phase.write <= HWRITE;
      phase.addr <= HADDR[`SSF_ADDR_WIDTH-1:0];
    end
  end

  // Writes are accepted and dropped; the word is hardware-owned
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      HRDATA <= 32'h0000_0000;
    else if (take && !HWRITE)
    begin
      case (HADDR[`SSF_ADDR_WIDTH-1:0])
        `SSF_ADDR_WIDTH'(`SSF_ADDR_STATUS): HRDATA <= status;
        `SSF_ADDR_WIDTH'(`SSF_ADDR_SOURCE):
          HRDATA <= {{(32-UNIT_MAP_W){1'b0}}, unit_map_ref};
        default: HRDATA <= 32'h0000_0000;
      endcase
    end
    else
      HRDATA <= 32'h0000_0000;
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = `SSF_HRESP_OKAY;

endmodule : ssf_status
`default_nettype wire
